// file: rtl/fop_pkg.sv
// Purpose: Constants, types and decode for flash option byte protection
// Assumes: Flash block bases and sizes as mapped on the system bus
// Notes:   Register offsets are byte addresses on the plain register port
package fop_pkg;
	// Address map
	localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
	localparam logic [31:0] MAIN_END  = 32'h0802_0000;
	localparam logic [31:0] MAIN_SIZE = 32'h0002_0000;
	localparam logic [31:0] FACT_BASE = 32'h0804_0000;
	localparam logic [31:0] CUST_BASE = 32'h0804_0800;
	localparam logic [31:0] CUST_END  = 32'h0804_1000;
	localparam logic [31:0] PAGE_SIZE = 32'h0000_0800;
	localparam logic [31:0] RAM_BASE  = 32'h2000_0000;
	localparam logic [31:0] RAM_END   = 32'h2000_3000;
	// Flash geometry: 64 pages of 2048 bytes, 4 pages per protect region
	localparam int          OFF_W     = 17;
	localparam int          PAGE_LSB  = 11;
	localparam int          PAGE_W    = 6;
	localparam int          RGN_LSB   = 2;
	localparam logic [5:0]  BOOT_PGS  = 6'h04;
	localparam logic [6:0]  OB_AREA   = 7'h00;
	// Option bytes
	localparam int          OB_NUM    = 8;
	localparam logic [3:0]  OB_CNT_END = 4'h8;
	localparam logic [2:0]  OB_LAST   = 3'h7;
	localparam int          OB_RDP    = 0;
	localparam int          OB_WP_LO  = 4;
	localparam int          OB_WP_HI  = 5;
	localparam logic [7:0]  RDP_OFF   = 8'hA5;
	localparam logic [15:0] OB_BLANK  = 16'hFFFF;
	localparam logic [15:0] WP_NONE   = 16'hFFFF;
	// RAM wait states in the fast clock mode
	localparam logic [1:0]  RAM_WS    = 2'h2;
	// Register port
	localparam logic [7:0]  REG_STATUS = 8'h00;
	localparam logic [7:0]  REG_CTRL   = 8'h04;
	localparam logic [7:0]  REG_OPT_LO = 8'h08;
	localparam logic [7:0]  REG_OPT_HI = 8'h0C;
	localparam int          SB_OBERR   = 0;
	localparam int          SB_RDP     = 1;
	localparam int          SB_INTR    = 2;
	localparam int          SB_REFUSED = 3;
	localparam int          SB_MON     = 4;
	localparam int          SB_READY   = 5;
	localparam int          SB_WP_LSB  = 16;
	localparam int          CT_CLR_REF = 0;
	localparam int          CT_RELOAD  = 1;

	typedef enum logic [4:0] {
		BLK_NONE = 5'h01,
		BLK_MAIN = 5'h02,
		BLK_FACT = 5'h04,
		BLK_CUST = 5'h08,
		BLK_RAM  = 5'h10
	} fop_blk_e;

	typedef enum logic [3:0] {
		ST_LOAD  = 4'h1,
		ST_CHECK = 4'h2,
		ST_RUN   = 4'h4,
		ST_FAULT = 4'h8
	} fop_st_e;

	// Which block an address hits; the zero alias only for the bus side
	function automatic fop_blk_e dec_blk(input logic [31:0] a,
		input logic mon, input logic alias_en);
		fop_blk_e b;
		b = BLK_NONE;
		if (alias_en && a < MAIN_SIZE)
			b = mon ? ((a < PAGE_SIZE) ? BLK_FACT : BLK_NONE) : BLK_MAIN;
		else if (a >= MAIN_BASE && a < MAIN_END)
			b = BLK_MAIN;
		else if (a >= FACT_BASE && a < CUST_BASE)
			b = BLK_FACT;
		else if (a >= CUST_BASE && a < CUST_END)
			b = BLK_CUST;
		else if (a >= RAM_BASE && a < RAM_END)
			b = BLK_RAM;
		return b;
	endfunction
endpackage

// file: rtl/fop_protect.sv
// Purpose: Flash and RAM mapping, option byte load and flash protection
// Assumes: arst_n is the full chip reset driven from the external reset pin
// Notes:   Option bytes are read from the customer page over a one-cycle port
`timescale 1ns/100ps
// Operation
// - Main flash 64 pages, info pages single 2048
// - Erase whole pages, program aligned half-words
// - Normal boot aliases main flash at zero
// - Factory page high; monitor boot aliases it
// - Factory page refuses user programming
// - Customer page mapped, never fetched
// - Option upper byte is hardware complement
// - Bad option complement halts the processor
// - Option bytes 4, 5 protect 16 regions
// - Protect bits active low, 0xFF unprotected
// - Protection applies after reset, blocks both
// - Read protection off only for 0xA5
// - Read protection changes only at chip reset
// - Debugger sets intrusion; pin reset clears
// - Protection plus intrusion blanks all flash
// - Erasing byte 0 while protected mass-erases
// - Read protection locks lowest four pages
// - 12 kB RAM, all access sizes
// - RAM two wait states in fast clock mode
module fop_protect (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        dbg_attach,
	input  wire logic        boot_mon,
	input  wire logic        clk_hi,
	output logic      [2:0]  ob_addr,
	input  wire logic [15:0] ob_rdata,
	output logic             cpu_hold,
	input  wire logic        bus_valid,
	input  wire logic [31:0] bus_addr,
	input  wire logic        bus_fetch,
	output logic             bus_sel_main,
	output logic             bus_sel_fact,
	output logic             bus_sel_cust,
	output logic             bus_sel_ram,
	output logic      [16:0] bus_off,
	output logic             bus_wait,
	output logic             bus_err,
	input  wire logic        cmd_prog,
	input  wire logic        cmd_erase,
	input  wire logic [31:0] cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	output logic             fl_prog,
	output logic             fl_erase,
	output logic             fl_mass,
	output logic             fl_cust,
	output logic      [16:0] fl_off,
	output logic      [15:0] fl_wdata,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	fop_pkg::fop_st_e  st_r;
	fop_pkg::fop_blk_e bus_blk;
	fop_pkg::fop_blk_e cmd_blk;
	logic [15:0]  opt_r [fop_pkg::OB_NUM];
	logic [7:0]   mis;
	logic [3:0]   ld_cnt_r;
	logic         cap_vld_r;
	logic [2:0]   cap_idx_r;
	logic         full_r;
	logic         rdp_r;
	logic [15:0]  wp_r;
	logic         intr_r;
	logic         mon_r;
	logic         ob_err_r;
	logic         refused_r;
	logic         refuse;
	logic [1:0]   dbg_s;
	logic [1:0]   mon_s;
	logic [1:0]   ws_r;
	logic         blank;
	logic         run;
	logic [5:0]   cmd_page;
	logic         cmd_prot;
	logic         cmd_opt;
	logic         prog_ok;
	logic         erase_ok;
	logic         ram_acc;
	logic         wr_ctrl;

	// Pin inputs pass two flops; only the second stage is read
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dbg_s <= 2'h0;
			mon_s <= 2'h0;
		end
		else
		begin
			dbg_s <= {dbg_s[0], dbg_attach};
			mon_s <= {mon_s[0], boot_mon};
		end
	end

	assign run     = (st_r == fop_pkg::ST_RUN);
	assign wr_ctrl = reg_wr && (reg_addr == fop_pkg::REG_CTRL);

	// Option load sequencer; a reload from software keeps read protection
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r     <= fop_pkg::ST_LOAD;
			ld_cnt_r <= 4'h0;
			full_r   <= 1'b1;
		end
		else if (wr_ctrl && reg_wdata[fop_pkg::CT_RELOAD])
		begin
			st_r     <= fop_pkg::ST_LOAD;
			ld_cnt_r <= 4'h0;
			full_r   <= 1'b0;
		end
		else
		begin
			unique case (st_r)
				fop_pkg::ST_LOAD:
				begin
					if (ld_cnt_r != fop_pkg::OB_CNT_END)
						ld_cnt_r <= ld_cnt_r + 4'h1;
					if (cap_vld_r && cap_idx_r == fop_pkg::OB_LAST)
						st_r <= fop_pkg::ST_CHECK;
				end
				fop_pkg::ST_CHECK:
					st_r <= (|mis) ? fop_pkg::ST_FAULT : fop_pkg::ST_RUN;
				fop_pkg::ST_RUN:
					st_r <= fop_pkg::ST_RUN;
				fop_pkg::ST_FAULT:
					st_r <= fop_pkg::ST_FAULT;
			endcase
		end
	end

	// One read in flight; the data of index k arrive one cycle after it
	assign ob_addr = ld_cnt_r[2:0];
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cap_vld_r <= 1'b0;
			cap_idx_r <= 3'h0;
		end
		else
		begin
			cap_vld_r <= (st_r == fop_pkg::ST_LOAD) && (ld_cnt_r != fop_pkg::OB_CNT_END);
			cap_idx_r <= ld_cnt_r[2:0];
		end
	end

	// Option storage and complement check; a fully erased slot counts as valid
	genvar gi;
	generate
		for (gi = 0; gi < fop_pkg::OB_NUM; gi++)
		begin : g_opt
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
					opt_r[gi] <= fop_pkg::OB_BLANK;
				else if (cap_vld_r && cap_idx_r == 3'(gi))
					opt_r[gi] <= ob_rdata;
			end
			assign mis[gi] = (opt_r[gi] != fop_pkg::OB_BLANK)
				&& (opt_r[gi][15:8] != ~opt_r[gi][7:0]);
		end
	endgenerate

	// Protection state taken at the end of the check
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdp_r    <= 1'b1;
			wp_r     <= fop_pkg::WP_NONE;
			ob_err_r <= 1'b0;
		end
		else if (st_r == fop_pkg::ST_CHECK)
		begin
			ob_err_r <= |mis;
			wp_r     <= {opt_r[fop_pkg::OB_WP_HI][7:0],
				opt_r[fop_pkg::OB_WP_LO][7:0]};
			if (full_r)
				rdp_r <= (opt_r[fop_pkg::OB_RDP][7:0] != fop_pkg::RDP_OFF);
		end
	end

	// Boot strap caught once per chip reset, at the check; the
	// synchroniser shows its reset value only for the first two cycles of the load
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			mon_r <= 1'b0;
		else if (st_r == fop_pkg::ST_CHECK && full_r)
			mon_r <= mon_s[1];
	end

	// Intrusion is sticky; only the pin-driven reset clears it
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			intr_r <= 1'b0;
		else if (dbg_s[1])
			intr_r <= 1'b1;
	end

	// A bad option set keeps the processor halted until a chip reset or a software reload
	assign cpu_hold = !run;
	assign blank    = rdp_r && intr_r;

	// Bus decode; flash fully cut off when blanked
	always_comb
	begin
		bus_blk = fop_pkg::dec_blk(bus_addr, mon_r, 1'b1);
		bus_sel_main = 1'b0;
		bus_sel_fact = 1'b0;
		bus_sel_cust = 1'b0;
		bus_sel_ram  = 1'b0;
		bus_err      = 1'b0;
		bus_off      = 17'h0;
		if (bus_valid)
		begin
			unique case (bus_blk)
				fop_pkg::BLK_MAIN:
				begin
					bus_sel_main = !blank;
					bus_off      = bus_addr[16:0];
				end
				fop_pkg::BLK_FACT:
				begin
					bus_sel_fact = !blank;
					bus_off      = {6'h0, bus_addr[10:0]};
				end
				fop_pkg::BLK_CUST:
				begin
					bus_sel_cust = !blank && !bus_fetch;
					bus_off      = {6'h0, bus_addr[10:0]};
				end
				fop_pkg::BLK_RAM:
				begin
					bus_sel_ram = 1'b1;
					bus_off     = {3'h0, bus_addr[13:0]};
				end
				fop_pkg::BLK_NONE:
					bus_off = 17'h0;
			endcase
			bus_err = !(bus_sel_main || bus_sel_fact || bus_sel_cust || bus_sel_ram);
		end
	end

	// RAM wait states in the fast clock mode; no software setting needed
	assign ram_acc  = bus_sel_ram && clk_hi;
	assign bus_wait = ram_acc && (ws_r != fop_pkg::RAM_WS);
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ws_r <= 2'h0;
		else if (ram_acc)
			ws_r <= (ws_r == fop_pkg::RAM_WS) ? 2'h0 : ws_r + 2'h1;
		else
			ws_r <= 2'h0;
	end

	// Command checks against the protection state
	always_comb
	begin
		cmd_blk  = fop_pkg::dec_blk(cmd_addr, mon_r, 1'b0);
		cmd_page = cmd_addr[fop_pkg::PAGE_LSB +: fop_pkg::PAGE_W];
		cmd_prot = !wp_r[cmd_page[5:fop_pkg::RGN_LSB]]
			|| (rdp_r && cmd_page < fop_pkg::BOOT_PGS);
		cmd_opt  = (cmd_addr[10:4] == fop_pkg::OB_AREA);
		// Factory page is never a legal target
		prog_ok  = run && !cmd_addr[0]
			&& ((cmd_blk == fop_pkg::BLK_MAIN && !cmd_prot) || cmd_blk == fop_pkg::BLK_CUST);
		erase_ok = run
			&& ((cmd_blk == fop_pkg::BLK_MAIN && !cmd_prot) || cmd_blk == fop_pkg::BLK_CUST);
		refuse   = cmd_prog ? !prog_ok : (cmd_erase && !erase_ok);
	end

	// Flash strobes follow the command inputs one cycle later; program wins over erase
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fl_prog  <= 1'b0;
			fl_erase <= 1'b0;
			fl_mass  <= 1'b0;
			fl_cust  <= 1'b0;
			fl_off   <= 17'h0;
			fl_wdata <= 16'h0;
		end
		else
		begin
			fl_prog  <= cmd_prog && prog_ok;
			fl_erase <= !cmd_prog && cmd_erase && erase_ok;
			// Erasing the option page while protected wipes main flash too
			fl_mass  <= !cmd_prog && cmd_erase && erase_ok
				&& cmd_blk == fop_pkg::BLK_CUST && rdp_r;
			if ((cmd_prog && prog_ok) || (cmd_erase && erase_ok))
			begin
				fl_cust <= (cmd_blk == fop_pkg::BLK_CUST);
				// Customer page offsets count from the start of that page
				if (cmd_blk == fop_pkg::BLK_CUST)
					fl_off <= cmd_prog ? {6'h0, cmd_addr[10:0]} : 17'h0;
				else if (cmd_prog)
					fl_off <= cmd_addr[16:0];
				else
					fl_off <= {cmd_addr[16:fop_pkg::PAGE_LSB], 11'h000};
				if (cmd_blk == fop_pkg::BLK_CUST && cmd_opt)
					fl_wdata <= {~cmd_wdata[7:0], cmd_wdata[7:0]};
				else
					fl_wdata <= cmd_wdata;
			end
		end
	end

	// Refused flag: a new refusal beats a clear in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			refused_r <= 1'b0;
		else if (refuse)
			refused_r <= 1'b1;
		else if (wr_ctrl && reg_wdata[fop_pkg::CT_CLR_REF])
			refused_r <= 1'b0;
	end

	// Register read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 32'h0;
		else if (!reg_rd)
			reg_rdata <= 32'h0;
		else
		begin
			unique case (reg_addr)
				fop_pkg::REG_STATUS:
				begin
					reg_rdata <= 32'h0;
					reg_rdata[fop_pkg::SB_OBERR]   <= ob_err_r;
					reg_rdata[fop_pkg::SB_RDP]     <= rdp_r;
					reg_rdata[fop_pkg::SB_INTR]    <= intr_r;
					reg_rdata[fop_pkg::SB_REFUSED] <= refused_r;
					reg_rdata[fop_pkg::SB_MON]     <= mon_r;
					reg_rdata[fop_pkg::SB_READY]   <= run;
					reg_rdata[fop_pkg::SB_WP_LSB +: 16] <= wp_r;
				end
				fop_pkg::REG_OPT_LO:
					reg_rdata <= {opt_r[3][7:0], opt_r[2][7:0], opt_r[1][7:0], opt_r[0][7:0]};
				fop_pkg::REG_OPT_HI:
					reg_rdata <= {opt_r[7][7:0], opt_r[6][7:0], opt_r[5][7:0], opt_r[4][7:0]};
				default:
					reg_rdata <= 32'h0;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	a_blank_flash: assert property (
		bus_valid && rdp_r && intr_r |-> !bus_sel_main && !bus_sel_fact && !bus_sel_cust)
		else $error("flash reachable while blanked");
	a_cust_no_fetch: assert property (
		bus_valid && bus_fetch |-> !bus_sel_cust)
		else $error("fetch from customer page");
	a_fact_no_prog: assert property (
		cmd_prog && cmd_blk == fop_pkg::BLK_FACT |=> !fl_prog && refused_r)
		else $error("factory page programmed");
	a_opt_inverse: assert property (
		fl_prog && fl_cust && fl_off[10:4] == fop_pkg::OB_AREA
		|-> fl_wdata[15:8] == ~fl_wdata[7:0])
		else $error("option complement not generated");
	a_ob_fault: assert property (
		st_r == fop_pkg::ST_CHECK && |mis |=> cpu_hold [*4])
		else $error("bad options let processor run");
	a_rdp_hold: assert property (
		!(st_r == fop_pkg::ST_CHECK && full_r) |=> $stable(rdp_r))
		else $error("read protection changed between resets");
	a_boot_lock: assert property (
		rdp_r && cmd_erase && !cmd_prog && cmd_blk == fop_pkg::BLK_MAIN
		&& cmd_page < fop_pkg::BOOT_PGS |=> !fl_erase && refused_r)
		else $error("boot pages erased under read protection");
	a_mass_erase: assert property (
		run && rdp_r && cmd_erase && !cmd_prog && cmd_blk == fop_pkg::BLK_CUST
		|=> fl_mass && fl_erase)
		else $error("no mass erase of main flash");
	a_prog_align: assert property (
		cmd_prog && cmd_addr[0] |=> !fl_prog)
		else $error("odd program address accepted");
	a_ram_wait: assert property (
		bus_sel_ram && clk_hi && ws_r == 2'h0
		|-> bus_wait ##1 (!(bus_sel_ram && clk_hi) || bus_wait))
		else $error("fast mode RAM wait missing");
	a_ram_done: assert property (
		bus_sel_ram && clk_hi && ws_r == 2'h0 ##1 (bus_sel_ram && clk_hi) [*2] |-> !bus_wait)
		else $error("fast mode RAM wait too long");
	a_wp_lock: assert property (
		cmd_erase && !cmd_prog && cmd_blk == fop_pkg::BLK_MAIN
		&& !wp_r[cmd_page[5:fop_pkg::RGN_LSB]] |=> !fl_erase)
		else $error("protected region erased");

	c_mass: cover property (fl_mass);
	c_refused: cover property (refuse ##1 refused_r);
	c_ram_ws: cover property (bus_wait ##1 bus_wait ##1 !bus_wait && bus_sel_ram);
	c_fault: cover property (st_r == fop_pkg::ST_FAULT);
endmodule

// file: verification/fop_ob_store.sv
// Purpose: Option half-word store seen by the protection loader
// Assumes: One-cycle registered read of the slot shown on ob_addr
// Notes:   A broken slot repeats its data byte, so its complement check fails unless that byte is 0xFF
`timescale 1ns/100ps
module fop_ob_store (
	input  wire logic        ref_clk,
	input  wire logic [2:0]  ob_addr,
	input  wire logic [63:0] ob_bytes,
	input  wire logic [7:0]  ob_break,
	output logic      [15:0] ob_rdata
);
	logic [7:0] b;

	// Stored form keeps the complement above the data byte
	assign b = ob_bytes[{ob_addr, 3'h0} +: 8];
	always_ff @(posedge ref_clk)
		ob_rdata <= ob_break[ob_addr] ? {b, b} : {~b, b};
endmodule

// file: verification/flash_option_byte_protection_test.sv
// Purpose: Self-checking bench for flash option byte protection
// Assumes: Option store model answers one cycle after the loader index
// Notes:   Each scenario task drives the block and judges its outputs
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module flash_option_byte_protection_test;
	localparam logic [63:0] OB_DEF = 64'hFFFF_FFFF_003C_00A5;
	logic        ref_clk = 1'b0, arst_n = 1'b0, dbg_attach = 1'b0, boot_mon = 1'b0;
	logic        clk_hi = 1'b0, bus_valid = 1'b0, bus_fetch = 1'b0;
	logic        cmd_prog = 1'b0, cmd_erase = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] bus_addr = 32'h0, cmd_addr = 32'h0, reg_wdata = 32'h0;
	logic [15:0] cmd_wdata = 16'h0;
	logic [7:0]  reg_addr = 8'h0, ob_break = 8'h0;
	logic [63:0] ob_bytes = OB_DEF;
	logic [2:0]  ob_addr;
	logic [15:0] ob_rdata, fl_wdata;
	logic [16:0] bus_off, fl_off;
	logic [31:0] reg_rdata, st;
	logic        cpu_hold, bus_sel_main, bus_sel_fact, bus_sel_cust, bus_sel_ram;
	logic        bus_wait, bus_err, fl_prog, fl_erase, fl_mass, fl_cust;
	int          fail_count = 0;
	int          checks_done = 0;

	fop_protect i_dut (.ref_clk, .arst_n, .dbg_attach, .boot_mon, .clk_hi, .ob_addr,
		.ob_rdata, .cpu_hold, .bus_valid, .bus_addr, .bus_fetch, .bus_sel_main,
		.bus_sel_fact, .bus_sel_cust, .bus_sel_ram, .bus_off, .bus_wait, .bus_err,
		.cmd_prog, .cmd_erase, .cmd_addr, .cmd_wdata, .fl_prog, .fl_erase, .fl_mass,
		.fl_cust, .fl_off, .fl_wdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	fop_ob_store i_store (.ref_clk, .ob_addr, .ob_bytes, .ob_break, .ob_rdata);

	// 100 MHz system clock
	always #5 ref_clk = ~ref_clk;

	// Full chip reset; the wait is bounded because a fault keeps the processor held
	task automatic chip_reset();
		int n;
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		n = 0;
		while (cpu_hold !== 1'b0 && n < 40)
		begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	// Register port read: data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic stat();
		rd(fop_pkg::REG_STATUS, st);
	endtask

	// One flash command, strobe check, refusal flag check, then clear the flag
	task automatic fc(input logic p, input logic [31:0] a, input logic [15:0] wd,
		input logic ok, input logic m);
		@(posedge ref_clk);
		cmd_prog  <= p;
		cmd_erase <= ~p;
		cmd_addr  <= a;
		cmd_wdata <= wd;
		@(posedge ref_clk);
		cmd_prog  <= 1'b0;
		cmd_erase <= 1'b0;
		#1;
		`CHK({fl_prog, fl_erase, fl_mass}, {p & ok, ~p & ok, m})
		stat();
		`CHK(st[fop_pkg::SB_REFUSED], ~ok)
		wr(fop_pkg::REG_CTRL, 32'h0000_0001);
	endtask

	// Bus decode: sel is {main, factory, customer, ram, err}
	task automatic bc(input logic [31:0] a, input logic f, input logic [4:0] sel,
		input logic [16:0] off);
		@(posedge ref_clk);
		bus_valid <= 1'b1;
		bus_addr  <= a;
		bus_fetch <= f;
		#1;
		`CHK({bus_sel_main, bus_sel_fact, bus_sel_cust, bus_sel_ram, bus_err}, sel)
		if (sel[0] == 1'b0)
			`CHK(bus_off, off)
	endtask

	task automatic t_map();
		bc(32'h0000_0000, 1'b1, 5'h10, 17'h0);
		bc(32'h0001_FFFE, 1'b0, 5'h10, 17'h1FFFE);
		bc(32'h0802_0000, 1'b0, 5'h01, 17'h0);
		bc(32'h0804_0000, 1'b1, 5'h08, 17'h0);
		bc(32'h0804_0FFE, 1'b0, 5'h04, 17'h7FE);
		bc(32'h0804_0800, 1'b1, 5'h01, 17'h0);
		bc(32'h2000_2FFF, 1'b1, 5'h02, 17'h2FFF);
		bc(32'h2000_3000, 1'b0, 5'h01, 17'h0);
		@(posedge ref_clk);
		bus_valid <= 1'b0;
		clk_hi    <= 1'b1;
		bc(32'h2000_0010, 1'b0, 5'h02, 17'h10);
		`CHK(bus_wait, 1'b1)
		@(posedge ref_clk);
		#1;
		`CHK(bus_wait, 1'b1)
		@(posedge ref_clk);
		#1;
		`CHK(bus_wait, 1'b0)
		@(posedge ref_clk);
		bus_valid <= 1'b0;
		clk_hi    <= 1'b0;
		bc(32'h2000_0010, 1'b0, 5'h02, 17'h10);
		`CHK(bus_wait, 1'b0)
		@(posedge ref_clk);
		bus_valid <= 1'b0;
	endtask

	task automatic t_mon();
		boot_mon <= 1'b1;
		chip_reset();
		bc(32'h0000_0000, 1'b1, 5'h08, 17'h0);
		bc(32'h0000_0800, 1'b1, 5'h01, 17'h0);
		bc(32'h0800_0000, 1'b1, 5'h10, 17'h0);
		@(posedge ref_clk);
		bus_valid <= 1'b0;
		boot_mon  <= 1'b0;
		chip_reset();
	endtask

	task automatic t_prog();
		stat();
		`CHK({st[31:16], st[5:0]}, {16'hFFFF, 6'h20})
		rd(fop_pkg::REG_OPT_LO, st);
		`CHK(st, 32'h003C_00A5)
		rd(8'h10, st);
		`CHK(st, 32'h0)
		fc(1'b1, 32'h0800_0002, 16'h1234, 1'b1, 1'b0);
		`CHK({fl_cust, fl_off, fl_wdata}, {1'b0, 17'h2, 16'h1234})
		fc(1'b1, 32'h0800_0003, 16'h1234, 1'b0, 1'b0);
		fc(1'b0, 32'h0800_1804, 16'h0, 1'b1, 1'b0);
		`CHK(fl_off, 17'h1800)
		fc(1'b1, 32'h0804_0010, 16'h0, 1'b0, 1'b0);
		fc(1'b0, 32'h0804_0000, 16'h0, 1'b0, 1'b0);
		fc(1'b1, 32'h0804_0808, 16'h5512, 1'b1, 1'b0);
		`CHK({fl_cust, fl_off, fl_wdata}, {1'b1, 17'h8, 16'hED12})
		fc(1'b0, 32'h0804_0800, 16'h0, 1'b1, 1'b0);
	endtask

	task automatic t_wp();
		@(posedge ref_clk);
		// Write protection paired with read protection, as software should
		ob_bytes <= 64'hFFFF_7FFE_003C_0000;
		chip_reset();
		stat();
		`CHK({st[31:16], st[fop_pkg::SB_RDP]}, {16'h7FFE, 1'b1})
		fc(1'b1, 32'h0800_1FFE, 16'h0, 1'b0, 1'b0);
		fc(1'b1, 32'h0800_2000, 16'h0, 1'b1, 1'b0);
		fc(1'b0, 32'h0801_E000, 16'h0, 1'b0, 1'b0);
		fc(1'b0, 32'h0801_DFFE, 16'h0, 1'b1, 1'b0);
		ob_bytes <= OB_DEF;
		fc(1'b1, 32'h0800_0000, 16'h0, 1'b0, 1'b0);
		chip_reset();
		fc(1'b1, 32'h0800_0000, 16'h0, 1'b1, 1'b0);
	endtask

	task automatic t_rdp();
		logic [7:0] v [5] = '{8'hA5, 8'h00, 8'hA4, 8'h5A, 8'hFF};
		foreach (v[i])
		begin
			@(posedge ref_clk);
			ob_bytes[7:0] <= v[i];
			chip_reset();
			stat();
			`CHK(st[fop_pkg::SB_RDP], v[i] != 8'hA5)
		end
		fc(1'b1, 32'h0800_1FFE, 16'h0, 1'b0, 1'b0);
		fc(1'b1, 32'h0800_2000, 16'h0, 1'b1, 1'b0);
		fc(1'b0, 32'h0804_0800, 16'h0, 1'b1, 1'b1);
		ob_bytes[7:0] <= 8'hA5;
		wr(fop_pkg::REG_CTRL, 32'h0000_0002);
		repeat (12) @(posedge ref_clk);
		stat();
		`CHK(st[fop_pkg::SB_RDP], 1'b1)
		chip_reset();
		stat();
		`CHK(st[fop_pkg::SB_RDP], 1'b0)
	endtask

	task automatic t_intr(input logic [7:0] rdp, input logic [4:0] sel);
		@(posedge ref_clk);
		ob_bytes[7:0] <= rdp;
		chip_reset();
		dbg_attach <= 1'b1;
		repeat (6) @(posedge ref_clk);
		dbg_attach <= 1'b0;
		repeat (6) @(posedge ref_clk);
		stat();
		`CHK(st[fop_pkg::SB_INTR], 1'b1)
		bc(32'h0800_0000, 1'b0, sel, 17'h0);
		bc(32'h2000_0000, 1'b0, 5'h02, 17'h0);
		@(posedge ref_clk);
		bus_valid <= 1'b0;
		chip_reset();
		stat();
		`CHK(st[fop_pkg::SB_INTR], 1'b0)
		bc(32'h0800_0000, 1'b0, 5'h10, 17'h0);
		@(posedge ref_clk);
		bus_valid <= 1'b0;
	endtask

	task automatic t_fault();
		@(posedge ref_clk);
		// Slot 2 holds a non-erased byte, so its repeated copy must fail the check
		ob_break <= 8'h04;
		chip_reset();
		stat();
		`CHK({cpu_hold, st[fop_pkg::SB_READY], st[fop_pkg::SB_OBERR]}, 3'h5)
		fc(1'b1, 32'h0800_2000, 16'h0, 1'b0, 1'b0);
		ob_break <= 8'h00;
		chip_reset();
		`CHK(cpu_hold, 1'b0)
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog: the scenarios need under a thousand cycles; the limit is 40000
	initial
	begin
		#400000;
		fail_count++;
		results();
	end

	initial
	begin
		chip_reset();
		t_map();
		t_mon();
		t_prog();
		t_wp();
		t_rdp();
		t_intr(8'hFF, 5'h01);
		t_intr(8'hA5, 5'h10);
		t_fault();
		results();
	end
endmodule
